// File: logic/alub_defs.svh
`ifndef ALUB_DEFS_SVH
`define ALUB_DEFS_SVH
// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define ALUB_OFF_CTRL 12'h000
`define ALUB_OFF_OPA 12'h004
`define ALUB_OFF_OPB 12'h008
`define ALUB_OFF_IMM 12'h00C
`define ALUB_OFF_RES 12'h010
`define ALUB_OFF_SR 12'h014
`define ALUB_OFF_STAT 12'h018
// ----------------------------------------
// Control fields
// ----------------------------------------
`define ALUB_CTRL_OP_LSB 0
`define ALUB_CTRL_COND_LSB 8
`define ALUB_CTRL_OFS_LSB 12
`define ALUB_CTRL_WID_LSB 17
`define ALUB_CTRL_SA_LSB 22
`define ALUB_CTRL_HSEL_BIT 27
`define ALUB_CTRL_COH_BIT 28
`define ALUB_CTRL_SDIR_BIT 29
`define ALUB_CTRL_START_BIT 31
// ----------------------------------------
// Status register flag positions
// ----------------------------------------
`define ALUB_SR_C 0
`define ALUB_SR_Z 1
`define ALUB_SR_N 2
`define ALUB_SR_V 3
`define ALUB_SR_Q 4
`define ALUB_SR_RESET 32'h0000_0000
`define ALUB_LATENCY 1
`endif

// File: logic/alub_pkg.sv
package alub_pkg;
  typedef enum logic [7:0] {
    OP_SUBHH, OP_SUBCOND, OP_TNBZ, OP_TST, OP_AND, OP_OR, OP_EOR, OP_ANDN, OP_COM,
    OP_ANDH, OP_ANDL, OP_EORH, OP_EORL, OP_ORH, OP_ORL, OP_BFINS, OP_BFEXTS, OP_BFEXTU,
    OP_CBR, OP_SBR, OP_CASTSB, OP_CASTSH, OP_CASTUB, OP_CASTUH, OP_SWAPB, OP_SWAPBH,
    OP_SWAPH, OP_ASR, OP_LSL, OP_LSR, OP_ROL, OP_ROR, OP_MOV, OP_MOVCOND, OP_CSRF,
    OP_SSRF, OP_CSRFCZ, OP_SRCOND, OP_CLZ, OP_BREV, OP_BLD, OP_BST
  } alub_op_e;
  typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ} alub_bus_e;
endpackage

// File: logic/alub_core.sv
// Added by the designer: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "alub_defs.svh"
// Combinational datapath: one operation per cycle, result and flags together.
module alub_core (
  input wire logic [7:0] op,
  input wire logic [3:0] cond,
  input wire logic [31:0] opa,
  input wire logic [31:0] opb,
  input wire logic [31:0] imm,
  input wire logic [4:0] ofs,
  input wire logic [4:0] wid,
  input wire logic [4:0] sa,
  input wire logic hsel,
  input wire logic clear_other_half,
  input wire logic sdir,
  input wire logic [31:0] sr_in,
  output logic [31:0] res,
  output logic wr_en,
  output logic [31:0] sr_out
);
  // ----------------------------------------
  // Condition evaluation
  // ----------------------------------------
  function automatic logic cond_ok(input logic [3:0] c, input logic [31:0] s);
    logic cf, zf, nf, vf;
    cf = s[`ALUB_SR_C];
    zf = s[`ALUB_SR_Z];
    nf = s[`ALUB_SR_N];
    vf = s[`ALUB_SR_V];
    case (c)
      4'h0: cond_ok = zf;
      4'h1: cond_ok = !zf;
      4'h2: cond_ok = cf;
      4'h3: cond_ok = !cf;
      4'h4: cond_ok = nf;
      4'h5: cond_ok = !nf;
      4'h6: cond_ok = !(nf ^ vf);
      4'h7: cond_ok = nf ^ vf;
      4'h8: cond_ok = vf;
      4'h9: cond_ok = !vf;
      4'hA: cond_ok = !zf && !(nf ^ vf);
      4'hB: cond_ok = zf || (nf ^ vf);
      4'hC: cond_ok = zf || cf;
      4'hD: cond_ok = !zf && !cf;
      4'hE: cond_ok = 1'b1;
      default: cond_ok = nf;
    endcase
  endfunction

  // Mask of the low w bits; width 0 is taken as all 32 bits
  function automatic logic [31:0] low_mask(input logic [4:0] w);
    low_mask = (w == 5'h00) ? 32'hFFFF_FFFF : ((32'h0000_0001 << w) - 32'h0000_0001);
  endfunction

  logic [31:0] bmir;
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_mir
      assign bmir[gi] = opa[31 - gi];
    end
  endgenerate

  // ----------------------------------------
  // Operation select
  // ----------------------------------------
  always_comb begin
    logic [31:0] sb, m, ext;
    logic [15:0] ha, hb;
    logic [4:0] amt;
    logic ok, setf;
    logic [5:0] lz;
    sb = sdir ? (opb >> sa) : (opb << sa);
    m = low_mask(wid);
    // Extracts read the source operand; the destination only receives the field
    ext = (opb >> ofs) & m;
    ha = hsel ? opa[31:16] : opa[15:0];
    hb = hsel ? opb[31:16] : opb[15:0];
    amt = opb[4:0];
    ok = cond_ok(cond, sr_in);
    setf = 1'b1;
    lz = 6'd32;
    // Leading zeros counted on the source operand
    for (int i = 0; i < 32; i++) begin
      if (opb[i]) begin
        lz = 6'(31 - i);
      end
    end
    res = opa;
    wr_en = 1'b1;
    sr_out = sr_in;
    case (alub_pkg::alub_op_e'(op))
      alub_pkg::OP_SUBHH: res = {{16{ha[15]}}, ha} - {{16{hb[15]}}, hb};
      alub_pkg::OP_SUBCOND: begin
        wr_en = ok;
        res = ok ? opa - imm : opa;
      end
      alub_pkg::OP_TNBZ: begin
        wr_en = 1'b0;
        setf = 1'b0;
        sr_out[`ALUB_SR_Z] = (opa[7:0] == 8'h00) || (opa[15:8] == 8'h00) ||
          (opa[23:16] == 8'h00) || (opa[31:24] == 8'h00);
        sr_out[`ALUB_SR_N] = 1'b0;
      end
      alub_pkg::OP_TST: begin
        wr_en = 1'b0;
        res = opa & opb;
      end
      alub_pkg::OP_AND: res = opa & sb;
      alub_pkg::OP_OR: res = opa | sb;
      alub_pkg::OP_EOR: res = opa ^ sb;
      alub_pkg::OP_ANDN: res = opa & ~opb;
      alub_pkg::OP_COM: res = ~opa;
      alub_pkg::OP_ANDH: res = {opa[31:16] & imm[15:0], clear_other_half ? 16'h0000 : opa[15:0]};
      alub_pkg::OP_ANDL: res = {clear_other_half ? 16'h0000 : opa[31:16], opa[15:0] & imm[15:0]};
      alub_pkg::OP_EORH: res = {opa[31:16] ^ imm[15:0], opa[15:0]};
      alub_pkg::OP_EORL: res = {opa[31:16], opa[15:0] ^ imm[15:0]};
      alub_pkg::OP_ORH: res = {opa[31:16] | imm[15:0], opa[15:0]};
      alub_pkg::OP_ORL: res = {opa[31:16], opa[15:0] | imm[15:0]};
      alub_pkg::OP_BFINS: res = (opa & ~(m << ofs)) | ((opb & m) << ofs);
      alub_pkg::OP_BFEXTS: begin
        res = ext;
        if (wid != 5'h00 && ext[wid - 5'h01]) begin
          res = ext | ~m;
        end
      end
      alub_pkg::OP_BFEXTU: res = ext;
      alub_pkg::OP_CBR: res = opa & ~(32'h0000_0001 << ofs);
      alub_pkg::OP_SBR: res = opa | (32'h0000_0001 << ofs);
      alub_pkg::OP_CASTSB: res = {{24{opa[7]}}, opa[7:0]};
      alub_pkg::OP_CASTSH: res = {{16{opa[15]}}, opa[15:0]};
      alub_pkg::OP_CASTUB: res = {24'h000000, opa[7:0]};
      alub_pkg::OP_CASTUH: res = {16'h0000, opa[15:0]};
      alub_pkg::OP_SWAPB: res = {opa[7:0], opa[15:8], opa[23:16], opa[31:24]};
      alub_pkg::OP_SWAPBH: res = {opa[23:16], opa[31:24], opa[7:0], opa[15:8]};
      alub_pkg::OP_SWAPH: res = {opa[15:0], opa[31:16]};
      // Amount from opb low bits; register form and in-place form share it
      alub_pkg::OP_ASR: res = 32'($signed(opa) >>> amt);
      alub_pkg::OP_LSL: res = opa << amt;
      alub_pkg::OP_LSR: res = opa >> amt;
      alub_pkg::OP_ROL: begin
        res = {opa[30:0], sr_in[`ALUB_SR_C]};
        sr_out[`ALUB_SR_C] = opa[31];
        setf = 1'b0;
        sr_out[`ALUB_SR_Z] = (res == 32'h0000_0000);
        sr_out[`ALUB_SR_N] = res[31];
      end
      alub_pkg::OP_ROR: begin
        res = {sr_in[`ALUB_SR_C], opa[31:1]};
        sr_out[`ALUB_SR_C] = opa[0];
        setf = 1'b0;
        sr_out[`ALUB_SR_Z] = (res == 32'h0000_0000);
        sr_out[`ALUB_SR_N] = res[31];
      end
      alub_pkg::OP_MOV: res = hsel ? imm : opb;
      alub_pkg::OP_MOVCOND: begin
        wr_en = ok;
        res = ok ? (hsel ? imm : opb) : opa;
        setf = 1'b0;
      end
      alub_pkg::OP_CSRF: begin
        wr_en = 1'b0;
        setf = 1'b0;
        sr_out[ofs] = 1'b0;
      end
      alub_pkg::OP_SSRF: begin
        wr_en = 1'b0;
        setf = 1'b0;
        sr_out[ofs] = 1'b1;
      end
      alub_pkg::OP_CSRFCZ: begin
        wr_en = 1'b0;
        setf = 1'b0;
        sr_out[`ALUB_SR_C] = sr_in[ofs];
        sr_out[`ALUB_SR_Z] = sr_in[ofs];
      end
      alub_pkg::OP_SRCOND: begin
        res = ok ? 32'h0000_0001 : 32'h0000_0000;
        setf = 1'b0;
      end
      alub_pkg::OP_CLZ: res = {26'h0000000, lz};
      alub_pkg::OP_BREV: res = bmir;
      alub_pkg::OP_BLD: begin
        wr_en = 1'b0;
        setf = 1'b0;
        sr_out[`ALUB_SR_C] = opa[ofs];
        sr_out[`ALUB_SR_Z] = opa[ofs];
      end
      alub_pkg::OP_BST: begin
        res = sr_in[`ALUB_SR_C] ? (opa | (32'h0000_0001 << ofs)) :
          (opa & ~(32'h0000_0001 << ofs));
        setf = 1'b0;
      end
      default: begin
        wr_en = 1'b0;
        setf = 1'b0;
      end
    endcase
    // Zero and negative flags follow the result unless the op sets them itself or keeps them
    if (setf) begin
      sr_out[`ALUB_SR_Z] = (res == 32'h0000_0000);
      sr_out[`ALUB_SR_N] = res[31];
    end
  end
endmodule
`default_nettype wire

// File: logic/alub_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "alub_defs.svh"
module alub_top (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  input wire logic HSEL,
  input wire logic [11:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic HREADY,
  input wire logic [31:0] HWDATA,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] RESULT,
  output logic RESULT_VALID
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [31:0] imm;
    logic [31:0] res;
    logic [31:0] sr;
    logic [31:0] rdata;
    logic [31:0] count;
    logic [11:0] addr;
    logic wr_pend;
    logic rd_pend;
    logic valid;
  } alub_state_s;

  alub_state_s st_reg;
  alub_state_s st_next;

  logic [31:0] core_res;
  logic core_wr;
  logic [31:0] core_sr;

  // ----------------------------------------
  // Datapath
  // ----------------------------------------
  alub_core u_core (
    .op(st_reg.ctrl[`ALUB_CTRL_OP_LSB +: 8]),
    .cond(st_reg.ctrl[`ALUB_CTRL_COND_LSB +: 4]),
    .opa(st_reg.opa),
    .opb(st_reg.opb),
    .imm(st_reg.imm),
    .ofs(st_reg.ctrl[`ALUB_CTRL_OFS_LSB +: 5]),
    .wid(st_reg.ctrl[`ALUB_CTRL_WID_LSB +: 5]),
    .sa(st_reg.ctrl[`ALUB_CTRL_SA_LSB +: 5]),
    .hsel(st_reg.ctrl[`ALUB_CTRL_HSEL_BIT]),
    .clear_other_half(st_reg.ctrl[`ALUB_CTRL_COH_BIT]),
    .sdir(st_reg.ctrl[`ALUB_CTRL_SDIR_BIT]),
    .sr_in(st_reg.sr),
    .res(core_res),
    .wr_en(core_wr),
    .sr_out(core_sr)
  );

  // Read mux used at the address phase
  function automatic logic [31:0] read_word(input logic [11:0] a, input alub_state_s s);
    case (a)
      `ALUB_OFF_CTRL: read_word = s.ctrl;
      `ALUB_OFF_OPA: read_word = s.opa;
      `ALUB_OFF_OPB: read_word = s.opb;
      `ALUB_OFF_IMM: read_word = s.imm;
      `ALUB_OFF_RES: read_word = s.res;
      `ALUB_OFF_SR: read_word = s.sr;
      `ALUB_OFF_STAT: read_word = s.count;
      default: read_word = 32'h0000_0000;
    endcase
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic take;
    st_next = st_reg;
    st_next.valid = 1'b0;
    take = HSEL && HREADY && HTRANS[1];
    // Write data phase: store HWDATA at the address latched in the address phase
    if (st_reg.wr_pend) begin
      case (st_reg.addr)
        `ALUB_OFF_CTRL: st_next.ctrl = {1'b0, HWDATA[30:0]};
        `ALUB_OFF_OPA: st_next.opa = HWDATA;
        `ALUB_OFF_OPB: st_next.opb = HWDATA;
        `ALUB_OFF_IMM: st_next.imm = HWDATA;
        `ALUB_OFF_SR: st_next.sr = HWDATA;
        default: st_next.count = st_reg.count;
      endcase
      // Start bit launches one operation in the following cycle
      if (st_reg.addr == `ALUB_OFF_CTRL && HWDATA[`ALUB_CTRL_START_BIT]) begin
        st_next.ctrl[`ALUB_CTRL_START_BIT] = 1'b1;
      end
    end
    // Execute in one cycle; result and flags visible to the next op
    if (st_reg.ctrl[`ALUB_CTRL_START_BIT]) begin
      st_next.ctrl[`ALUB_CTRL_START_BIT] = 1'b0;
      st_next.sr = core_sr;
      st_next.valid = core_wr;
      st_next.count = st_reg.count + 32'h0000_0001;
      if (core_wr) begin
        st_next.res = core_res;
        st_next.opa = core_res; // In-place destination for chaining
      end
    end
    // Read word captured at the address phase from the settled next state, so the
    // data phase shows a flop and still sees a write or an op finishing there
    if (take && !HWRITE) begin
      st_next.rdata = read_word({HADDR[11:2], 2'b00}, st_next);
    end
    st_next.wr_pend = take && HWRITE;
    st_next.rd_pend = take && !HWRITE;
    if (take) begin
      st_next.addr = {HADDR[11:2], 2'b00};
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      st_reg <= '0;
    end else if (CLK_EN) begin
      st_reg <= st_next;
    end
  end

  // Data and result outputs straight from state; the bus never inserts wait states
  always_comb begin
    HRDATA = st_reg.rdata;
    HREADYOUT = 1'b1;
    HRESP = 1'b0;
    RESULT = st_reg.res;
    RESULT_VALID = st_reg.valid;
  end
endmodule
`default_nettype wire

// File: tb/alub_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "alub_defs.svh"
// ----------------------------------------
// Port checks of the ALU block
// ----------------------------------------
module alub_top_sva (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic HSEL,
  input wire logic [11:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HWDATA,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic [31:0] RESULT,
  input wire logic RESULT_VALID
);
  logic take;
  logic go;
  logic ctrl_wr_reg;
  logic res_rd_reg;
  logic gap_rd_reg;
  // Address phase taken at this edge
  assign take = HSEL && HREADY && HTRANS[1];
  assign go = ctrl_wr_reg && HWDATA[31];
  // No reset needed: bus stays idle while reset is low
  always_ff @(posedge REF_CLK) begin
    ctrl_wr_reg <= take && HWRITE && HADDR == `ALUB_OFF_CTRL;
    res_rd_reg <= take && !HWRITE && HADDR == `ALUB_OFF_RES;
    gap_rd_reg <= take && !HWRITE && HADDR == 12'h020;
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  a_ready_high: assert property (HREADYOUT == 1'b1)
    else $error("hreadyout low");
  a_resp_okay: assert property (HRESP == 1'b0)
    else $error("hresp not okay");
  a_move_latency: assert property (go && HWDATA[7:0] == alub_pkg::OP_MOV
    |-> ##[1:3] RESULT_VALID) else $error("move result late");
  a_test_nowrite: assert property (go && HWDATA[7:0] inside {alub_pkg::OP_TST,
    alub_pkg::OP_TNBZ, alub_pkg::OP_CSRF, alub_pkg::OP_SSRF} |=> !RESULT_VALID [*3])
    else $error("flag-only op wrote a result");
  a_result_held: assert property ($changed(RESULT) |-> RESULT_VALID)
    else $error("result moved without a write");
  a_valid_cause: assert property (RESULT_VALID
    |-> $past(go, 1) || $past(go, 2) || $past(go, 3))
    else $error("result pulse without a start");
  a_res_mirror: assert property (res_rd_reg |-> HRDATA == RESULT)
    else $error("result register differs from port");
  a_gap_zero: assert property (gap_rd_reg |-> HRDATA == 32'h00000000)
    else $error("unmapped read not zero");
  a_reset_clear: assert property ($rose(RESET_N) |-> RESULT == 32'h0 && !RESULT_VALID)
    else $error("result not cleared by reset");
endmodule
bind alub_top alub_top_sva u_sva (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .HSEL(HSEL),
  .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HWDATA(HWDATA),
  .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .RESULT(RESULT),
  .RESULT_VALID(RESULT_VALID));
`default_nettype wire

// File: tb/alub_ahb_master.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Single-transfer bus master
// ----------------------------------------
module alub_ahb_master (
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [11:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [31:0] hwdata
);
  int n_stall;
  // Idle bus from time zero
  initial begin
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h00000000;
    n_stall = 0;
  end
  // Bounded wait, so a stuck slave cannot hang the run
  task automatic wait_ready();
    int k;
    k = 0;
    @(posedge clk);
    while (hready !== 1'b1 && k < 32) begin
      @(posedge clk);
      k++;
    end
    if (k >= 32) n_stall++;
  endtask
  // Address phase held until taken, then data phase
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask
endmodule
`default_nettype wire

// File: tb/alub_logic_bitfield_shift_ops_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "alub_defs.svh"
module alu_logic_bitfield_shift_ops_tb;
  logic ref_clk;
  logic reset_n;
  logic clk_en;
  logic [2:0] hsize;
  logic hsel;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] result;
  logic result_valid;
  logic [31:0] scratch;
  int n_errors;
  int num_checks;
  // Single slave: its ready is the bus ready
  alub_top dut (.REF_CLK(ref_clk), .RESET_N(reset_n), .CLK_EN(clk_en), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HREADY(hreadyout),
    .HWDATA(hwdata), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .RESULT(result), .RESULT_VALID(result_valid));
  alub_ahb_master bfm (.clk(ref_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bfm.xfer(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  // Control word; start bit added by run
  function automatic logic [31:0] cw(alub_pkg::alub_op_e o, int of = 0, int wd = 0,
    int s = 0, int x = 0, int cd = 0);
    return {2'b00, 3'(x), 5'(s), 5'(wd), 5'(of), 4'(cd), o};
  endfunction
  // Load operands, start, watch the pulse, compare result
  task automatic run(input logic [31:0] c, input logic [31:0] a, input logic [31:0] b,
    input logic [31:0] i, input logic [31:0] e, input bit w = 1'b1);
    logic [31:0] q;
    logic seen;
    bfm.xfer(1'b1, `ALUB_OFF_OPA, a, q);
    bfm.xfer(1'b1, `ALUB_OFF_OPB, b, q);
    bfm.xfer(1'b1, `ALUB_OFF_IMM, i, q);
    bfm.xfer(1'b1, `ALUB_OFF_CTRL, c | 32'h80000000, q);
    seen = 1'b0;
    // Fixed window: latency is fixed by the block
    repeat (5) begin
      @(negedge ref_clk);
      seen = seen | (result_valid === 1'b1);
    end
    chk({31'h0, seen}, {31'h0, w});
    chk(result, e);
    rdchk(`ALUB_OFF_RES, 32'hFFFFFFFF, e);
  endtask
  // Watchdog ends a hung run as a failure
  initial begin
    #200000;
    n_errors++;
    final_report();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    n_errors = 0;
    num_checks = 0;
    reset_n = 1'b0;
    clk_en = 1'b1;
    hsize = 3'h2;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    run(cw(alub_pkg::OP_MOV), '0, 32'h0000000C, '0, 32'h0000000C);
    run(cw(alub_pkg::OP_SUBHH, 0, 0, 0, 1), 32'h80000000, 32'h00010000, '0, 32'hFFFF7FFF);
    run(cw(alub_pkg::OP_BFINS, 4, 8), 32'hFFFFFFFF, '0, '0, 32'hFFFFF00F);
    run(cw(alub_pkg::OP_BFEXTS, 4, 8), '0, 32'h00000A50, '0, 32'hFFFFFFA5);
    run(cw(alub_pkg::OP_BFEXTU, 4, 8), '0, 32'h00000A50, '0, 32'h000000A5);
    run(cw(alub_pkg::OP_CBR, 31), 32'hFFFFFFFF, '0, '0, 32'h7FFFFFFF);
    run(cw(alub_pkg::OP_SBR, 0), '0, '0, '0, 32'h00000001);
    run(cw(alub_pkg::OP_CASTSB), 32'h00001280, '0, '0, 32'hFFFFFF80);
    run(cw(alub_pkg::OP_CASTSH), 32'h00008001, '0, '0, 32'hFFFF8001);
    run(cw(alub_pkg::OP_CASTUB), 32'hFFFFFF80, '0, '0, 32'h00000080);
    run(cw(alub_pkg::OP_CASTUH), 32'hFFFF8001, '0, '0, 32'h00008001);
    run(cw(alub_pkg::OP_SWAPB), 32'h11223344, '0, '0, 32'h44332211);
    run(cw(alub_pkg::OP_SWAPBH), 32'h11223344, '0, '0, 32'h22114433);
    run(cw(alub_pkg::OP_SWAPH), 32'h11223344, '0, '0, 32'h33441122);
    run(cw(alub_pkg::OP_ASR), 32'h80000000, 32'h4, '0, 32'hF8000000);
    run(cw(alub_pkg::OP_LSL), 32'h00000001, 32'h1F, '0, 32'h80000000);
    run(cw(alub_pkg::OP_LSR), 32'h80000000, 32'h1F, '0, 32'h00000001);
    run(cw(alub_pkg::OP_AND, 0, 0, 8), 32'hFFFFFFFF, 32'hFF, '0, 32'h0000FF00);
    run(cw(alub_pkg::OP_OR, 0, 0, 24, 4), '0, 32'hFF000000, '0, 32'h000000FF);
    run(cw(alub_pkg::OP_EOR, 0, 0, 4), 32'hFFFFFFFF, 32'hF, '0, 32'hFFFFFF0F);
    run(cw(alub_pkg::OP_ANDH), 32'hFFFFFFFF, '0, 32'hFF, 32'h00FFFFFF);
    run(cw(alub_pkg::OP_ANDL, 0, 0, 0, 2), 32'hFFFFFFFF, '0, 32'hFF, 32'h000000FF);
    run(cw(alub_pkg::OP_EORH), 32'h12345678, '0, 32'hFFFF, 32'hEDCB5678);
    run(cw(alub_pkg::OP_EORL), 32'h12345678, '0, 32'hFFFF, 32'h1234A987);
    run(cw(alub_pkg::OP_CLZ), '0, 32'h00001000, '0, 32'h00000013);
    run(cw(alub_pkg::OP_BREV), 32'h00000001, '0, '0, 32'h80000000);
    run(cw(alub_pkg::OP_SSRF, 1), '0, '0, '0, 32'h80000000, 1'b0);
    rdchk(`ALUB_OFF_SR, 32'h2, 32'h2);
    run(cw(alub_pkg::OP_MOVCOND), '0, 32'h5A5A5A5A, '0, 32'h5A5A5A5A);
    run(cw(alub_pkg::OP_MOVCOND, 0, 0, 0, 1), '0, '0, 32'h77, 32'h00000077);
    run(cw(alub_pkg::OP_CSRF, 1), '0, '0, '0, 32'h00000077, 1'b0);
    rdchk(`ALUB_OFF_SR, 32'h2, 32'h0);
    run(cw(alub_pkg::OP_MOVCOND), '0, 32'h1234, '0, 32'h00000077, 1'b0);
    run(cw(alub_pkg::OP_SRCOND), 32'h55, '0, '0, 32'h00000000);
    run(cw(alub_pkg::OP_SRCOND, 0, 0, 0, 0, 14), 32'h55, '0, '0, 32'h00000001);
    run(cw(alub_pkg::OP_SUBCOND, 0, 0, 0, 0, 1), 32'h10, '0, 32'h3, 32'h0000000D);
    run(cw(alub_pkg::OP_SUBCOND), 32'h10, '0, 32'h3, 32'h0000000D, 1'b0);
    run(cw(alub_pkg::OP_SSRF, 0), '0, '0, '0, 32'h0000000D, 1'b0);
    run(cw(alub_pkg::OP_ROL), 32'h80000000, '0, '0, 32'h00000001);
    rdchk(`ALUB_OFF_SR, 32'h1, 32'h1);
    run(cw(alub_pkg::OP_ROR), 32'h00000002, '0, '0, 32'h80000001);
    rdchk(`ALUB_OFF_SR, 32'h1, 32'h0);
    run(cw(alub_pkg::OP_TNBZ), 32'h11002233, '0, '0, 32'h80000001, 1'b0);
    rdchk(`ALUB_OFF_SR, 32'h2, 32'h2);
    run(cw(alub_pkg::OP_TST), 32'hF0, 32'h30, '0, 32'h80000001, 1'b0);
    rdchk(`ALUB_OFF_SR, 32'h2, 32'h0);
    run(cw(alub_pkg::OP_SSRF, 2), '0, '0, '0, 32'h80000001, 1'b0);
    run(cw(alub_pkg::OP_CSRFCZ, 2), '0, '0, '0, 32'h80000001, 1'b0);
    rdchk(`ALUB_OFF_SR, 32'h3, 32'h3);
    // Unmapped place and read-only result ignore writes
    bfm.xfer(1'b1, 12'h020, 32'hDEADBEEF, scratch);
    bfm.xfer(1'b1, `ALUB_OFF_RES, 32'hDEADBEEF, scratch);
    rdchk(12'h020, 32'hFFFFFFFF, 32'h00000000);
    rdchk(`ALUB_OFF_RES, 32'hFFFFFFFF, 32'h80000001);
    // Clock enable low freezes all state, so a write made then is lost
    bfm.xfer(1'b1, `ALUB_OFF_OPA, 32'h00001111, scratch);
    @(posedge ref_clk);
    clk_en <= 1'b0;
    bfm.xfer(1'b1, `ALUB_OFF_OPA, 32'h00002222, scratch);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    rdchk(`ALUB_OFF_OPA, 32'hFFFFFFFF, 32'h00001111);
    n_errors += bfm.n_stall;
    final_report();
  end
endmodule
`default_nettype wire
